// ==== logic/ref_ctrl_pkg.sv ====
// Purpose: Constants and carriers for the fixed reference control block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: One register word, control byte in the low bits
package ref_ctrl_pkg;

  localparam logic [3:0] REFERENCE_CONTROL_OFFSET = 4'h0;
  localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h00;
  localparam int ENABLE_BIT = 7;
  localparam int READY_BIT = 6;
  localparam int RESERVED_HI = 5;
  localparam int RESERVED_LO = 4;
  localparam int CDAC_GAIN_HI = 3;
  localparam int CDAC_GAIN_LO = 2;
  localparam int CONV_GAIN_HI = 1;
  localparam int CONV_GAIN_LO = 0;
  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GAIN_OFF,
    GAIN_X1,
    GAIN_X2,
    GAIN_X4
  } gain_t;

  // Analog-side controls
  typedef struct packed {
    logic reference_enable;
    logic cdac_amp_on;
    logic [2:0] cdac_gain_onehot;
    logic conv_amp_on;
    logic [2:0] conv_gain_onehot;
  } analog_ctrl_t;

endpackage

// ==== logic/fixed_reference_control.sv ====
// Purpose: Reference control register with ready flag and two gain fields
// Assumes: AXI4-Lite slave, analog core reports stable level synchronously
// Notes: Answers two cycles after both write channels are taken, one cycle after the read address
`timescale 1ns/10ps
`default_nettype none

module fixed_reference_control #(
  parameter bit HAS_LDO = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog core
  input wire logic analog_stable,
  output ref_ctrl_pkg::analog_ctrl_t analog_ctrl
);

  typedef struct packed {
    logic enable;
    logic [1:0] cdac_gain;
    logic [1:0] conv_gain;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic ready_flag;
  logic [7:0] reg_view;

  // ---------------------------------------------------------------
  // Status and analog decode
  // ---------------------------------------------------------------
  assign ready_flag = HAS_LDO ? 1'b1 : (st_r.enable & analog_stable);

  always_comb
  begin
    reg_view = 8'h00;
    reg_view[ref_ctrl_pkg::ENABLE_BIT] = st_r.enable;
    reg_view[ref_ctrl_pkg::READY_BIT] = ready_flag;
    reg_view[ref_ctrl_pkg::CDAC_GAIN_HI:ref_ctrl_pkg::CDAC_GAIN_LO] = st_r.cdac_gain;
    reg_view[ref_ctrl_pkg::CONV_GAIN_HI:ref_ctrl_pkg::CONV_GAIN_LO] = st_r.conv_gain;
  end

  always_comb
  begin
    analog_ctrl.reference_enable = st_r.enable;
    analog_ctrl.cdac_amp_on = (st_r.cdac_gain != ref_ctrl_pkg::GAIN_OFF);
    analog_ctrl.cdac_gain_onehot = {st_r.cdac_gain == ref_ctrl_pkg::GAIN_X4,
                                    st_r.cdac_gain == ref_ctrl_pkg::GAIN_X2,
                                    st_r.cdac_gain == ref_ctrl_pkg::GAIN_X1};
    analog_ctrl.conv_amp_on = (st_r.conv_gain != ref_ctrl_pkg::GAIN_OFF);
    analog_ctrl.conv_gain_onehot = {st_r.conv_gain == ref_ctrl_pkg::GAIN_X4,
                                    st_r.conv_gain == ref_ctrl_pkg::GAIN_X2,
                                    st_r.conv_gain == ref_ctrl_pkg::GAIN_X1};
  end

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  assign s_axi_awready = ~st_r.aw_held & ~st_r.bvalid;
  assign s_axi_wready = ~st_r.w_held & ~st_r.bvalid;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

  always_comb
  begin
    st_nxt = st_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb0 = s_axi_wstrb[0];
    end
    if (st_r.aw_held && st_r.w_held)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      if (st_r.aw_addr[3:2] == ref_ctrl_pkg::REFERENCE_CONTROL_OFFSET[3:2])
      begin
        st_nxt.bresp = ref_ctrl_pkg::AXI_RESP_OKAY;
        if (st_r.w_strb0)
        begin
          st_nxt.enable = st_r.w_data[ref_ctrl_pkg::ENABLE_BIT];
          st_nxt.cdac_gain =
            st_r.w_data[ref_ctrl_pkg::CDAC_GAIN_HI:ref_ctrl_pkg::CDAC_GAIN_LO];
          st_nxt.conv_gain =
            st_r.w_data[ref_ctrl_pkg::CONV_GAIN_HI:ref_ctrl_pkg::CONV_GAIN_LO];
        end
      end
      else
      begin
        st_nxt.bresp = ref_ctrl_pkg::AXI_RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rvalid = 1'b1;
      if (s_axi_araddr[3:2] == ref_ctrl_pkg::REFERENCE_CONTROL_OFFSET[3:2])
      begin
        st_nxt.rresp = ref_ctrl_pkg::AXI_RESP_OKAY;
        st_nxt.rdata = {24'h000000, reg_view};
      end
      else
      begin
        st_nxt.rresp = ref_ctrl_pkg::AXI_RESP_SLVERR;
        st_nxt.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_read_ctrl;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h0;
  endsequence

  property p_enable_drives;
    @(posedge mclk) disable iff (!rst_b)
      (st_r.aw_held && st_r.w_held && st_r.aw_addr[3:2] == 2'h0 && st_r.w_strb0)
      |=> analog_ctrl.reference_enable == $past(st_r.w_data[7]);
  endproperty
  a_enable_drives: assert property (p_enable_drives) else $error("enable not driven");

  property p_ready_needs_stable;
    @(posedge mclk) disable iff (!rst_b)
      (!HAS_LDO && s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready)
       && s_axi_rresp == 2'h0) |-> (!s_axi_rdata[6] || $past(analog_stable));
  endproperty
  a_ready_needs_stable: assert property (p_ready_needs_stable) else $error("ready early");

  property p_ready_read;
    @(posedge mclk) disable iff (!rst_b)
      s_read_ctrl |=> s_axi_rdata[6] == $past(ready_flag);
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("ready bit wrong");

  property p_ready_low_disabled;
    @(posedge mclk) disable iff (!rst_b)
      (!HAS_LDO && !st_r.enable) |-> !ready_flag;
  endproperty
  a_ready_low_disabled: assert property (p_ready_low_disabled) else $error("ready high");

  property p_ready_high;
    @(posedge mclk) disable iff (!rst_b)
      (st_r.enable && analog_stable) |-> ready_flag;
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("ready low");

  property p_ldo_ready;
    @(posedge mclk) disable iff (!rst_b)
      HAS_LDO |-> ready_flag;
  endproperty
  a_ldo_ready: assert property (p_ldo_ready) else $error("ldo ready low");

  property p_cdac_write;
    @(posedge mclk) disable iff (!rst_b)
      (st_r.aw_held && st_r.w_held && st_r.aw_addr[3:2] == 2'h0 && st_r.w_strb0)
      |=> st_r.cdac_gain == $past(st_r.w_data[3:2]) && s_axi_bvalid;
  endproperty
  a_cdac_write: assert property (p_cdac_write) else $error("cdac gain not stored");

  property p_cdac_off;
    @(posedge mclk) disable iff (!rst_b)
      (st_r.cdac_gain == 2'h0) |-> !analog_ctrl.cdac_amp_on
      && analog_ctrl.cdac_gain_onehot == 3'h0;
  endproperty
  a_cdac_off: assert property (p_cdac_off) else $error("cdac not off");

  property p_cdac_gain;
    @(posedge mclk) disable iff (!rst_b)
      (st_r.cdac_gain != 2'h0) |-> analog_ctrl.cdac_gain_onehot
      == (3'h1 << (st_r.cdac_gain - 2'h1));
  endproperty
  a_cdac_gain: assert property (p_cdac_gain) else $error("cdac gain wrong");

  property p_conv_gain;
    @(posedge mclk) disable iff (!rst_b)
      analog_ctrl.conv_amp_on == (st_r.conv_gain != 2'h0)
      && (st_r.conv_gain == 2'h3) == analog_ctrl.conv_gain_onehot[2];
  endproperty
  a_conv_gain: assert property (p_conv_gain) else $error("conv gain wrong");

endmodule

`default_nettype wire

// ==== sim/analog_core_model.sv ====
// Purpose: Analog reference core stand-in
// Assumes: Stable reported a fixed count after enable
// Notes: Stable drops on the first clock edge after enable falls
`timescale 1ns/10ps
`default_nettype none
module analog_core_model #(
  parameter int SETTLE = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Analog side
  input wire ref_ctrl_pkg::analog_ctrl_t analog_ctrl,
  output logic analog_stable
);
  int cnt_r;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b || !analog_ctrl.reference_enable)
      cnt_r <= 0;
    else if (cnt_r < SETTLE)
      cnt_r <= cnt_r + 1;
  end
  assign analog_stable = (cnt_r == SETTLE);
endmodule
`default_nettype wire

// ==== sim/fixed_reference_control_tb_top.sv ====
// Purpose: Self-checking bench for the reference control register
// Assumes: Analog model settles 8 cycles after enable
// Notes: One AXI4-Lite task serves reads and writes
`timescale 1ns/10ps
`default_nettype none
module fixed_reference_control_tb_top;
  logic mclk = 1'b0, rst_b = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rdata_l;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, stable;
  logic [1:0] bresp, rresp;
  ref_ctrl_pkg::analog_ctrl_t actl;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  always #5 mclk = ~mclk;
  fixed_reference_control dut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .analog_stable(stable), .analog_ctrl(actl));
  analog_core_model #(.SETTLE(8)) core (.mclk(mclk), .rst_b(rst_b), .analog_ctrl(actl),
    .analog_stable(stable));
  // Regulator variant, fed the same bus; only its read data is judged
  fixed_reference_control #(.HAS_LDO(1'b1)) dut_ldo (.mclk(mclk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(), .s_axi_rdata(rdata_l), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(rready), .analog_stable(stable), .analog_ctrl());
  function automatic logic [2:0] oh(input logic [1:0] c);
    return (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write when we, else read; d is write data or expected read data
  task automatic bus(input bit we, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] e);
    bit done;
    done = 1'b0;
    // One idle edge so a strobe is never lowered and raised in one step
    @(posedge mclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= we;
    wvalid <= we;
    bready <= we;
    arvalid <= !we;
    rready <= !we;
    while (!done)
    begin
      @(posedge mclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if ((bready && bvalid) || (rready && rvalid))
      begin
        bready <= 1'b0;
        rready <= 1'b0;
        if (!we)
          chk(rdata, d);
        if (!we)
          chk(rdata_l, (e == 2'h0) ? (d | 32'h40) : d);
        chk(32'(we ? bresp : rresp), 32'(e));
        done = 1'b1;
      end
    end
  endtask
  task automatic t_enable;
    bus(1'b1, 4'h0, 32'hff, 4'hf, 2'h0);
    bus(1'b0, 4'h0, 32'h8f, 4'h0, 2'h0);
    repeat (10) @(posedge mclk);
    bus(1'b0, 4'h0, 32'hcf, 4'h0, 2'h0);
    chk(32'(actl.reference_enable), 32'h1);
  endtask
  task automatic t_gains;
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      bus(1'b1, 4'h0, {24'h0, 4'h8, c, ~c}, 4'h1, 2'h0);
      bus(1'b0, 4'h0, {24'h0, 4'hc, c, ~c}, 4'h0, 2'h0);
      chk(32'(actl), 32'({1'b1, c != 2'h0, oh(c), ~c != 2'h0, oh(~c)}));
    end
  endtask
  task automatic t_refuse;
    bus(1'b1, 4'h0, 32'h0, 4'h0, 2'h0);
    bus(1'b1, 4'h4, 32'h0, 4'hf, 2'h2);
    bus(1'b0, 4'h4, 32'h0, 4'h0, 2'h2);
    bus(1'b0, 4'h0, 32'hcc, 4'h0, 2'h0);
  endtask
  task automatic t_reset;
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    chk(32'(actl), 32'h0);
    bus(1'b0, 4'h0, 32'h0, 4'h0, 2'h0);
  endtask
  task automatic t_disable;
    bus(1'b1, 4'h0, 32'h0, 4'hf, 2'h0);
    chk(32'(actl), 32'h0);
    bus(1'b0, 4'h0, 32'h0, 4'h0, 2'h0);
  endtask
  task automatic end_of_test;
    $display("Mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 4'h0, 2'h0);
    t_enable();
    t_gains();
    t_refuse();
    t_reset();
    t_disable();
    end_of_test();
  end
endmodule
`default_nettype wire
